// file: bench/scpc_card_model.sv
// Card side model: answers the C4, C8, IO and external data contacts.
// Assumes pads are registered on core_clk; a pad not driven by the block is driven here.
`timescale 1ns/1ps
module scpc_card_model
	import scpc_pkg::*;
(
	input  wire logic                   core_clk,
	input  wire scpc_pkg::scpc_pad_type c4_pad,
	input  wire scpc_pkg::scpc_pad_type c8_pad,
	input  wire scpc_pkg::scpc_pad_type io_pad,
	input  wire scpc_pkg::scpc_pad_type sio_pad,
	output logic                        c4_pin_in,
	output logic                        c8_pin_in,
	output logic                        io_pin_in,
	output logic                        sio_pin_in
);
	logic pat = 1'b0;
	// Toggling pattern so a released line never shows a stale level
	always @(posedge core_clk) begin
		pat <= ~pat;
	end
	// Wire level from the block's enable: its output when enabled, the card pattern otherwise
	assign c4_pin_in  = c4_pad.oe ? c4_pad.o : pat;
	assign c8_pin_in  = c8_pad.oe ? c8_pad.o : ~pat;
	assign io_pin_in  = io_pad.oe ? io_pad.o : pat;
	assign sio_pin_in = sio_pad.oe ? sio_pad.o : ~pat;
endmodule

// file: bench/tb_top.sv
// Self-checking bench of the protocol configuration registers.
// Assumes the card model on the contacts and firmware-like register access.
`timescale 1ns/1ps
module tb_top;
	import scpc_pkg::*;
	logic core_clk, rstn, wr_stb, rd_stb, tx_last, msg_start;
	logic [15:0] addr;
	logic [7:0] wr_data, rd_data;
	logic c4_i, c8_i, io_i, sio_i, rst_pin, card_clk, ext_card_clk, int_tick;
	scpc_pad_type c4_pad, c8_pad, io_pad, sio_pad;
	scpc_byte_type tx_byte, check_byte;
	logic isync, esync, nine, proto, chk_act, ctype, atr;
	int fail_count = 0;
	int samples_checked = 0;
	logic [7:0] msg [3] = '{8'h5A, 8'h3C, 8'h81};
	logic [15:0] crc_exp;
	// Bit-serial reference CRC over the test message, LSB first, kept apart from the byte-wise design form
	function automatic logic [15:0] ref_crc();
		logic [15:0] c;
		c = CHK_INIT;
		for (int i = 0; i < 3; i++) begin
			for (int j = 0; j < 8; j++) begin
				c = (c[0] ^ msg[i][j]) ? ((c >> 1) ^ CHK_POLY) : (c >> 1);
			end
		end
		return c;
	endfunction
	scpc_config i_scpc_config (.core_clk(core_clk), .rstn(rstn), .ce(1'b1), .addr(addr), .wr_data(wr_data),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .c4_pin_in(c4_i), .c8_pin_in(c8_i),
		.io_pin_in(io_i), .sio_pin_in(sio_i), .c4_pad(c4_pad), .c8_pad(c8_pad), .io_pad(io_pad),
		.sio_pad(sio_pad), .rst_pin(rst_pin), .card_clk(card_clk), .ext_card_clk(ext_card_clk),
		.uart_io(2'b00), .uart_rst(1'b0), .tx_byte(tx_byte), .tx_last(tx_last), .rx_byte(9'h000),
		.msg_start(msg_start), .check_byte(check_byte), .sync_rx_byte(), .int_sync_mode(isync),
		.ext_sync_mode(esync), .nine_bit_word_select(nine), .protocol_select(proto),
		.check_active(chk_act), .check_type_select(ctype), .atr_timeout_enable(atr),
		.int_etu_tick(int_tick), .ext_etu_tick());
	scpc_card_model i_scpc_card_model (.core_clk(core_clk), .c4_pad(c4_pad), .c8_pad(c8_pad),
		.io_pad(io_pad), .sio_pad(sio_pad), .c4_pin_in(c4_i), .c8_pin_in(c8_i), .io_pin_in(io_i),
		.sio_pin_in(sio_i));
	// 200 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic results();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge core_clk);
		wr_stb <= 1'b0;
		@(posedge core_clk);
		#1;
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge core_clk);
		rd_stb <= 1'b0;
		#1;
		cmp({8'h00, rd_data}, {8'h00, exp});
	endtask
	// Cycles between two divider ticks, after the new divisor has landed
	task automatic tick_gap(input int exp);
		int n;
		repeat (3) begin
			n = 0;
			@(posedge core_clk);
			while (int_tick !== 1'b1 && n < 300) begin
				@(posedge core_clk);
				n++;
			end
		end
		n = 1;
		@(posedge core_clk);
		while (int_tick !== 1'b1 && n < 300) begin
			@(posedge core_clk);
			n++;
		end
		cmp(16'(n), 16'(exp));
	endtask
	// Message with block check; expect cnt appended bytes, e0 first and then e1
	task automatic send_msg(input logic [7:0] mode, input int cnt, input logic [7:0] e0, input logic [7:0] e1);
		int n;
		int k;
		wr(ADDR_PROTOCOL_MODE, mode);
		@(posedge core_clk);
		msg_start <= 1'b1;
		@(posedge core_clk);
		msg_start <= 1'b0;
		foreach (msg[i]) begin
			@(posedge core_clk);
			tx_byte <= {1'b1, msg[i]};
			tx_last <= (i == 2);
		end
		@(posedge core_clk);
		tx_byte <= 9'h000;
		tx_last <= 1'b0;
		k = 0;
		for (n = 0; n < 5; n++) begin
			@(posedge core_clk);
			#1;
			if (check_byte.valid === 1'b1) begin
				cmp({8'h00, check_byte.data}, {8'h00, (k == 0) ? e0 : e1});
				k++;
			end
		end
		cmp(16'(k), 16'(cnt));
	endtask
	// Sync modes hand RST, IO and external data to firmware bits, and give them back afterwards
	task automatic sync_route();
		wr(ADDR_CONTACT_CONTROL, 8'h50);
		wr(ADDR_EXT_CONTACT_CONTROL, 8'h20);
		wr(ADDR_PROTOCOL_MODE, 8'hA0);
		cmp({13'h0000, rst_pin, io_pad.oe, io_pad.o}, 16'h0007);
		cmp({14'h0000, sio_pad.oe, sio_pad.o}, 16'h0003);
		wr(ADDR_PROTOCOL_MODE, 8'h00);
		cmp({13'h0000, rst_pin, io_pad.oe, io_pad.o}, 16'h0000);
		cmp({14'h0000, sio_pad.oe, sio_pad.o}, 16'h0001);
	endtask
	initial begin
		rstn = 1'b0;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		addr = 16'h0000;
		wr_data = 8'h00;
		tx_byte = 9'h000;
		tx_last = 1'b0;
		msg_start = 1'b0;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		// Reset values and tri-stated contacts
		rd_chk(ADDR_CONTACT_DIRECTION, 8'h00);
		rd_chk(ADDR_PROTOCOL_MODE, 8'h03);
		rd_chk(ADDR_CARD_CLOCK_DIVIDER, 8'h0C);
		cmp({14'h0000, c4_pad.oe, c8_pad.oe}, 16'h0000);
		tick_gap(13);
		// Direction bits, unused bits read zero
		wr(ADDR_CONTACT_DIRECTION, 8'hFF);
		rd_chk(ADDR_CONTACT_DIRECTION, 8'h0C);
		cmp({14'h0000, c4_pad.oe, c8_pad.oe}, 16'h0000);
		wr(ADDR_CONTACT_DIRECTION, 8'h04);
		#5;
		cmp({14'h0000, c4_pad.oe, c8_pad.oe}, 16'h0001);
		wr(ADDR_CONTACT_DIRECTION, 8'h08);
		#5;
		cmp({14'h0000, c4_pad.oe, c8_pad.oe}, 16'h0002);
		// Mode bits reach their outputs; reserved bit written as zero
		wr(ADDR_PROTOCOL_MODE, 8'hEF);
		rd_chk(ADDR_PROTOCOL_MODE, 8'hEF);
		#5;
		cmp({9'h000, isync, nine, esync, proto, chk_act, ctype, atr}, 16'h007F);
		wr(ADDR_PROTOCOL_MODE, 8'h00);
		cmp({10'h000, isync, nine, esync, proto, ctype, atr}, 16'h0000);
		sync_route();
		// Divider: ratios, zero as one, upper bits ignored
		wr(ADDR_CARD_CLOCK_DIVIDER, 8'h03);
		tick_gap(4);
		wr(ADDR_CARD_CLOCK_DIVIDER, 8'h00);
		tick_gap(2);
		wr(ADDR_CARD_CLOCK_DIVIDER, 8'hC1);
		rd_chk(ADDR_CARD_CLOCK_DIVIDER, 8'h01);
		tick_gap(2);
		// Block check only in T=1: LRC is the byte XOR, CRC goes out complemented, high byte first
		crc_exp = ref_crc();
		send_msg(8'h0C, 1, 8'hE7, 8'h00);
		rd_chk(ADDR_CHECK_RESULT_LO, 8'hE7);
		rd_chk(ADDR_CHECK_RESULT_HI, 8'h00);
		send_msg(8'h0E, 2, ~crc_exp[15:8], ~crc_exp[7:0]);
		rd_chk(ADDR_CHECK_RESULT_LO, crc_exp[7:0]);
		rd_chk(ADDR_CHECK_RESULT_HI, crc_exp[15:8]);
		send_msg(8'h04, 0, 8'h00, 8'h00);
		results();
	end
	// Watchdog well beyond the expected few hundred cycles
	initial begin
		#200us;
		fail_count++;
		results();
	end
endmodule

// file: include/scpc_pkg.sv
// Constants, register map and carrier types of the smart card protocol configuration block.
// Assumes a byte-wide register port with 16-bit addresses and one master clock.
package scpc_pkg;

	// Register addresses
	localparam logic [15:0] ADDR_CONTACT_CONTROL     = 16'hFE0A;
	localparam logic [15:0] ADDR_EXT_CONTACT_CONTROL = 16'hFE0B;
	localparam logic [15:0] ADDR_CONTACT_DIRECTION   = 16'hFE0C;
	localparam logic [15:0] ADDR_PROTOCOL_MODE       = 16'hFE0D;
	localparam logic [15:0] ADDR_CARD_CLOCK_DIVIDER  = 16'hFE0F;
	localparam logic [15:0] ADDR_EXT_CLOCK_DIVIDER   = 16'hFE10;
	localparam logic [15:0] ADDR_RECEIVE_CONTROL     = 16'hFE1D;
	localparam logic [15:0] ADDR_CHECK_RESULT_LO     = 16'hFE1E;
	localparam logic [15:0] ADDR_CHECK_RESULT_HI     = 16'hFE1F;

	// Reset values and writable masks
	localparam logic [7:0] DIR_RESET   = 8'h00;
	localparam logic [7:0] DIR_MASK    = 8'h0C;
	localparam logic [7:0] PMODE_RESET = 8'h03;
	localparam logic [7:0] PMODE_MASK  = 8'hEF;
	localparam logic [7:0] CTL_RESET   = 8'h00;
	localparam logic [7:0] CTL_MASK    = 8'h7F;
	localparam logic [7:0] ECTL_RESET  = 8'h00;
	localparam logic [7:0] ECTL_MASK   = 8'h33;
	localparam int         DIV_W       = 6;
	localparam logic [5:0] DIV_RESET   = 6'h0C;
	localparam logic [5:0] DIV_ONE     = 6'h01;

	// Field positions
	localparam int DIR_C4_BIT     = 2;
	localparam int DIR_C8_BIT     = 3;
	localparam int PM_ATR_BIT     = 0;
	localparam int PM_CTYPE_BIT   = 1;
	localparam int PM_CHKEN_BIT   = 2;
	localparam int PM_PROTO_BIT   = 3;
	localparam int PM_ESYNC_BIT   = 5;
	localparam int PM_NINE_BIT    = 6;
	localparam int PM_ISYNC_BIT   = 7;
	localparam int CTL_CLKOFF_BIT = 0;
	localparam int CTL_CLKLVL_BIT = 1;
	localparam int CTL_C4_BIT     = 2;
	localparam int CTL_C8_BIT     = 3;
	localparam int CTL_IO_BIT     = 4;
	localparam int CTL_IOD_BIT    = 5;
	localparam int CTL_RST_BIT    = 6;
	localparam int ECTL_OFF_BIT   = 0;
	localparam int ECTL_LVL_BIT   = 1;
	localparam int ECTL_SIOD_BIT  = 4;
	localparam int ECTL_SIO_BIT   = 5;

	// Pin synchroniser lanes
	localparam int PIN_C4  = 0;
	localparam int PIN_C8  = 1;
	localparam int PIN_IO  = 2;
	localparam int PIN_SIO = 3;

	// Synchronous word layout
	localparam logic [3:0] LAST_DATA_POS = 4'h7;
	localparam logic [3:0] NINTH_POS     = 4'h8;

	// Block check: reflected CRC-16 and its start value
	localparam logic [15:0] CHK_INIT = 16'hFFFF;
	localparam logic [15:0] CHK_POLY = 16'h8408;

	typedef struct packed {
		logic o;
		logic oe;
	} scpc_pad_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} scpc_byte_type;

	// One byte folded into the CRC, LSB first
	function automatic logic [15:0] scpc_crc_step(input logic [15:0] crc, input logic [7:0] d);
		logic [15:0] r;
		r = crc ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CHK_POLY) : (r >> 1);
		end
		return r;
	endfunction

endpackage

// file: src/scpc_clk_div.sv
// Card clock divider: master clock divided by (value+1) gives the ETU tick, then by 2 gives the card clock.
// Assumes the divisor input is a register on the same clock.
`timescale 1ns/1ps
module scpc_clk_div
	import scpc_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire logic             ce,
	input  wire logic [DIV_W-1:0] divisor,
	output logic                  tick,
	output logic                  clk_out
);
	import scpc_pkg::*;

	logic [DIV_W-1:0] cnt_r;
	logic [DIV_W-1:0] lim_r;
	logic             tick_r;
	logic             clk_r;

	// Zero is treated as one so the divider never stalls
	function automatic logic [DIV_W-1:0] eff_div(input logic [DIV_W-1:0] d);
		return (d == '0) ? DIV_ONE : d;
	endfunction

	// load at period end
	// New ratio taken only at terminal count, so no runt half-period reaches the card
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r  <= '0;
			lim_r  <= DIV_RESET;
			tick_r <= 1'b0;
			clk_r  <= 1'b0;
		end else if (ce) begin
			if (cnt_r >= lim_r) begin
				cnt_r  <= '0;
				lim_r  <= eff_div(divisor);
				tick_r <= 1'b1;
				clk_r  <= ~clk_r;
			end else begin
				cnt_r  <= cnt_r + DIV_ONE;
				tick_r <= 1'b0;
			end
		end
	end

	assign tick    = tick_r;
	assign clk_out = clk_r;

	chk_div_glitch_free: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && (cnt_r < lim_r) |=> $stable(lim_r) && $stable(clk_r))
		else $error("divider ratio or clock changed mid period");
	chk_div_never_zero: assert property (@(posedge core_clk) disable iff (!rstn)
		lim_r != '0)
		else $error("divider ratio reached zero");
endmodule

// file: src/scpc_config.sv
// Protocol configuration registers of an ISO 7816 card UART: contact routing, modes, clocks, block check.
// Assumes a byte register port answered one cycle later, and card pins passed in as separate in/out/enable.
// Functional notes
// - C8 direction bit: one makes C8 an input, zero an output.
// - C4 direction bit: one makes C4 an input, zero an output.
// - C4 and C8 stay tri-stated after reset until direction is written.
// - Internal sync mode drives RST, IO, C4, C8 from contact control; clock from divider.
// - Nine-bit sync words: eight bits to receive stream, ninth to receive control.
// - External sync mode drives data pin from external control; external clock from divider.
// - Protocol select picks T=0 at zero, T=1 at one.
// - Block check works only in T=1; ignored under T=0.
// - Check value appended right after the last transmitted byte.
// - Check value computed over received bytes, readable in two result registers.
// - Check type select: one is CRC, zero is LRC.
// - ATR timeout enable bit switches the answer-to-reset timeout on or off.
// - Master clock divided by divisor+1 for ETU, then by two for card clock.
// - Internal divisor resets to twelve, a ratio of thirteen.
// - New divisor applies after the write without clock glitches.
// - Divisor zero behaves as divisor one.
// - External data bit captures data pin at latest external clock rising edge.
// - External clock derived the same way from its own divisor.
`timescale 1ns/1ps
module scpc_config
	import scpc_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic                    rstn,
	input  wire logic                    ce,
	input  wire logic [15:0]             addr,
	input  wire logic [7:0]              wr_data,
	input  wire logic                    wr_stb,
	input  wire logic                    rd_stb,
	output logic [7:0]                   rd_data,
	input  wire logic                    c4_pin_in,
	input  wire logic                    c8_pin_in,
	input  wire logic                    io_pin_in,
	input  wire logic                    sio_pin_in,
	output scpc_pkg::scpc_pad_type       c4_pad,
	output scpc_pkg::scpc_pad_type       c8_pad,
	output scpc_pkg::scpc_pad_type       io_pad,
	output scpc_pkg::scpc_pad_type       sio_pad,
	output logic                         rst_pin,
	output logic                         card_clk,
	output logic                         ext_card_clk,
	input  wire scpc_pkg::scpc_pad_type  uart_io,
	input  wire logic                    uart_rst,
	input  wire scpc_pkg::scpc_byte_type tx_byte,
	input  wire logic                    tx_last,
	input  wire scpc_pkg::scpc_byte_type rx_byte,
	input  wire logic                    msg_start,
	output scpc_pkg::scpc_byte_type      check_byte,
	output scpc_pkg::scpc_byte_type      sync_rx_byte,
	output logic                         int_sync_mode,
	output logic                         ext_sync_mode,
	output logic                         nine_bit_word_select,
	output logic                         protocol_select,
	output logic                         check_active,
	output logic                         check_type_select,
	output logic                         atr_timeout_enable,
	output logic                         int_etu_tick,
	output logic                         ext_etu_tick
);
	import scpc_pkg::*;

	typedef enum logic [1:0] {CHK_IDLE, CHK_SEND_HI, CHK_SEND_LO} scpc_chk_state_type;

	logic [7:0]         dir_r;
	logic               dir_prog_r;
	logic [7:0]         pmode_r;
	logic [7:0]         ctl_r;
	logic [7:0]         ectl_r;
	logic [DIV_W-1:0]   idiv_r;
	logic [DIV_W-1:0]   ediv_r;
	logic [3:0]         sync1_r;
	logic [3:0]         sync2_r;
	logic               sio_cap_r;
	logic [7:0]         rd_data_r;
	logic [7:0]         rd_nxt;
	logic               int_tick_w;
	logic               int_clk_w;
	logic               ext_tick_w;
	logic               ext_clk_w;
	logic [7:0]         sh_r;
	logic [3:0]         bits_r;
	logic               ninth_r;
	logic               sync_rise_w;
	logic               sync_bit_w;
	logic [15:0]        acc_r;
	scpc_chk_state_type chk_state_r;
	scpc_pad_type       c4_pad_r;
	scpc_pad_type       c8_pad_r;
	scpc_pad_type       io_pad_r;
	scpc_pad_type       sio_pad_r;
	logic               rst_pin_r;
	logic               card_clk_r;
	logic               ext_card_clk_r;
	logic               check_active_r;
	scpc_byte_type      check_byte_r;
	scpc_byte_type      sync_rx_byte_r;

	function automatic logic hit(input logic [15:0] a);
		return wr_stb && (addr == a);
	endfunction

	// Register writes; reserved bits are masked off so they read back zero
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			dir_r      <= DIR_RESET;
			dir_prog_r <= 1'b0;
			pmode_r    <= PMODE_RESET;
			ctl_r      <= CTL_RESET;
			ectl_r     <= ECTL_RESET;
			idiv_r     <= DIV_RESET;
			ediv_r     <= DIV_RESET;
		end else if (ce) begin
			if (hit(ADDR_CONTACT_DIRECTION)) begin
				dir_r      <= wr_data & DIR_MASK;
				dir_prog_r <= 1'b1;
			end
			if (hit(ADDR_PROTOCOL_MODE)) pmode_r <= wr_data & PMODE_MASK;
			if (hit(ADDR_CONTACT_CONTROL)) ctl_r <= wr_data & CTL_MASK;
			if (hit(ADDR_EXT_CONTACT_CONTROL)) ectl_r <= wr_data & ECTL_MASK;
			if (hit(ADDR_CARD_CLOCK_DIVIDER)) idiv_r <= wr_data[DIV_W-1:0];
			if (hit(ADDR_EXT_CLOCK_DIVIDER)) ediv_r <= wr_data[DIV_W-1:0];
		end
	end

	// Two-stage synchronisers for every card pin
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
		end else if (ce) begin
			sync1_r <= {sio_pin_in, io_pin_in, c8_pin_in, c4_pin_in};
			sync2_r <= sync1_r;
		end
	end

	scpc_clk_div u_int_div (
		.core_clk (core_clk),
		.rstn     (rstn),
		.ce       (ce),
		.divisor  (idiv_r),
		.tick     (int_tick_w),
		.clk_out  (int_clk_w)
	);

	scpc_clk_div u_ext_div (
		.core_clk (core_clk),
		.rstn     (rstn),
		.ce       (ce),
		.divisor  (ediv_r),
		.tick     (ext_tick_w),
		.clk_out  (ext_clk_w)
	);

	// Rising card clock edge: the tick that turned the clock high
	assign sync_rise_w = pmode_r[PM_ISYNC_BIT] ? (int_tick_w & int_clk_w)
	                   : (pmode_r[PM_ESYNC_BIT] & ext_tick_w & ext_clk_w);
	assign sync_bit_w  = pmode_r[PM_ISYNC_BIT] ? sync2_r[PIN_IO] : sync2_r[PIN_SIO];

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sio_cap_r <= 1'b0;
		end else if (ce && pmode_r[PM_ESYNC_BIT] && ext_tick_w && ext_clk_w) begin
			sio_cap_r <= sync2_r[PIN_SIO];
		end
	end

	// sync word shifter
	// Bits arrive LSB first; ninth bit is parked apart from the byte stream
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sh_r           <= 8'h00;
			bits_r         <= 4'h0;
			ninth_r        <= 1'b0;
			sync_rx_byte_r <= '0;
		end else if (ce) begin
			sync_rx_byte_r.valid <= 1'b0;
			if (sync_rise_w) begin
				if (bits_r == NINTH_POS) begin
					ninth_r <= sync_bit_w;
					bits_r  <= 4'h0;
				end else begin
					sh_r   <= {sync_bit_w, sh_r[7:1]};
					bits_r <= bits_r + 4'h1;
					if (bits_r == LAST_DATA_POS) begin
						sync_rx_byte_r <= '{valid: 1'b1, data: {sync_bit_w, sh_r[7:1]}};
						bits_r         <= pmode_r[PM_NINE_BIT] ? NINTH_POS : 4'h0;
					end
				end
			end else if (!(pmode_r[PM_ISYNC_BIT] | pmode_r[PM_ESYNC_BIT])) begin
				bits_r <= 4'h0;
			end
		end
	end

	// Contact pads; C4/C8 enables stay low until direction is first written
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			c4_pad_r  <= '0;
			c8_pad_r  <= '0;
			io_pad_r  <= '0;
			sio_pad_r <= '0;
			rst_pin_r <= 1'b0;
		end else if (ce) begin
			c4_pad_r <= '{o: ctl_r[CTL_C4_BIT], oe: dir_prog_r & ~dir_r[DIR_C4_BIT]};
			c8_pad_r <= '{o: ctl_r[CTL_C8_BIT], oe: dir_prog_r & ~dir_r[DIR_C8_BIT]};
			if (pmode_r[PM_ISYNC_BIT]) begin
				io_pad_r  <= '{o: ctl_r[CTL_IO_BIT], oe: ~ctl_r[CTL_IOD_BIT]};
				rst_pin_r <= ctl_r[CTL_RST_BIT];
			end else begin
				io_pad_r  <= uart_io;
				rst_pin_r <= uart_rst;
			end
			sio_pad_r <= '{o: ectl_r[ECTL_SIO_BIT],
			               oe: pmode_r[PM_ESYNC_BIT] & ~ectl_r[ECTL_SIOD_BIT]};
		end
	end

	// Card clocks; stop level applies while the stop bit is set
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			card_clk_r     <= 1'b0;
			ext_card_clk_r <= 1'b0;
		end else if (ce) begin
			card_clk_r     <= ctl_r[CTL_CLKOFF_BIT] ? ctl_r[CTL_CLKLVL_BIT] : int_clk_w;
			ext_card_clk_r <= ectl_r[ECTL_OFF_BIT] ? ectl_r[ECTL_LVL_BIT] : ext_clk_w;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			check_active_r <= 1'b0;
		end else if (ce) begin
			check_active_r <= pmode_r[PM_PROTO_BIT] & pmode_r[PM_CHKEN_BIT];
		end
	end

	// CRC or LRC
	// Half duplex link, so one accumulator serves transmit and receive
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			acc_r <= CHK_INIT;
		end else if (ce) begin
			if (msg_start) begin
				acc_r <= pmode_r[PM_CTYPE_BIT] ? CHK_INIT : 16'h0000;
			end else if (check_active_r && (tx_byte.valid || rx_byte.valid)) begin
				acc_r <= pmode_r[PM_CTYPE_BIT]
				       ? scpc_crc_step(acc_r, tx_byte.valid ? tx_byte.data : rx_byte.data)
				       : {8'h00, acc_r[7:0] ^ (tx_byte.valid ? tx_byte.data : rx_byte.data)};
			end
		end
	end

	// append after last byte
	// CRC goes out high byte first; LRC is a single byte
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			chk_state_r  <= CHK_IDLE;
			check_byte_r <= '0;
		end else if (ce) begin
			check_byte_r.valid <= 1'b0;
			unique case (chk_state_r)
				CHK_IDLE: begin
					if (check_active_r && tx_byte.valid && tx_last)
						chk_state_r <= pmode_r[PM_CTYPE_BIT] ? CHK_SEND_HI : CHK_SEND_LO;
				end
				CHK_SEND_HI: begin
					check_byte_r <= '{valid: 1'b1, data: ~acc_r[15:8]};
					chk_state_r  <= CHK_SEND_LO;
				end
				CHK_SEND_LO: begin
					check_byte_r <= '{valid: 1'b1,
					                  data: pmode_r[PM_CTYPE_BIT] ? ~acc_r[7:0] : acc_r[7:0]};
					chk_state_r  <= CHK_IDLE;
				end
			endcase
		end
	end

	// Read mux; inputs read the synchronised pin, outputs the stored bit, except the external data bit in external sync mode, which reads the capture
	always_comb begin
		rd_nxt = 8'h00;
		unique case (addr)
			ADDR_CONTACT_DIRECTION:   rd_nxt = dir_r;
			ADDR_PROTOCOL_MODE:       rd_nxt = pmode_r;
			ADDR_CARD_CLOCK_DIVIDER:  rd_nxt = {2'b00, idiv_r};
			ADDR_EXT_CLOCK_DIVIDER:   rd_nxt = {2'b00, ediv_r};
			ADDR_RECEIVE_CONTROL:     rd_nxt = {7'h00, ninth_r};
			ADDR_CHECK_RESULT_LO:     rd_nxt = acc_r[7:0];
			ADDR_CHECK_RESULT_HI:     rd_nxt = acc_r[15:8];
			ADDR_CONTACT_CONTROL: begin
				rd_nxt = ctl_r;
				if (dir_r[DIR_C4_BIT]) rd_nxt[CTL_C4_BIT] = sync2_r[PIN_C4];
				if (dir_r[DIR_C8_BIT]) rd_nxt[CTL_C8_BIT] = sync2_r[PIN_C8];
				if (ctl_r[CTL_IOD_BIT]) rd_nxt[CTL_IO_BIT] = sync2_r[PIN_IO];
			end
			ADDR_EXT_CONTACT_CONTROL: begin
				rd_nxt = ectl_r;
				if (pmode_r[PM_ESYNC_BIT]) rd_nxt[ECTL_SIO_BIT] = sio_cap_r;
				else if (ectl_r[ECTL_SIOD_BIT]) rd_nxt[ECTL_SIO_BIT] = sync2_r[PIN_SIO];
			end
			default: rd_nxt = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rd_data_r <= 8'h00;
		end else if (ce) begin
			rd_data_r <= rd_stb ? rd_nxt : 8'h00;
		end
	end

	assign rd_data              = rd_data_r;
	assign c4_pad               = c4_pad_r;
	assign c8_pad               = c8_pad_r;
	assign io_pad               = io_pad_r;
	assign sio_pad              = sio_pad_r;
	assign rst_pin              = rst_pin_r;
	assign card_clk             = card_clk_r;
	assign ext_card_clk         = ext_card_clk_r;
	assign check_byte           = check_byte_r;
	assign sync_rx_byte         = sync_rx_byte_r;
	assign int_sync_mode        = pmode_r[PM_ISYNC_BIT];
	assign ext_sync_mode        = pmode_r[PM_ESYNC_BIT];
	assign nine_bit_word_select = pmode_r[PM_NINE_BIT];
	assign protocol_select      = pmode_r[PM_PROTO_BIT];
	assign check_active         = check_active_r;
	assign check_type_select    = pmode_r[PM_CTYPE_BIT];
	assign atr_timeout_enable   = pmode_r[PM_ATR_BIT];
	assign int_etu_tick         = int_tick_w;
	assign ext_etu_tick         = ext_tick_w;

	chk_c8_dir_output: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && dir_prog_r && !dir_r[DIR_C8_BIT] |=> c8_pad.oe && (c8_pad.o == $past(ctl_r[CTL_C8_BIT])))
		else $error("C8 not driven as output");
	chk_c4_dir_input: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && dir_r[DIR_C4_BIT] |=> !c4_pad.oe)
		else $error("C4 driven while set as input");
	chk_tristate_reset: assert property (@(posedge core_clk) disable iff (!rstn)
		!dir_prog_r |-> !c4_pad.oe && !c8_pad.oe)
		else $error("C4 or C8 driven before direction written");
	chk_sync_io_route: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && pmode_r[PM_ISYNC_BIT] && !ctl_r[CTL_IOD_BIT]
		|=> io_pad.oe && (io_pad.o == $past(ctl_r[CTL_IO_BIT])))
		else $error("IO not routed to firmware bit in sync mode");
	chk_ninth_bit_store: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && sync_rise_w && (bits_r == NINTH_POS) |=> (ninth_r == $past(sync_bit_w)) && !sync_rx_byte.valid)
		else $error("ninth bit not stored apart");
	chk_ext_sio_capture: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && pmode_r[PM_ESYNC_BIT] && ext_tick_w && ext_clk_w |=> sio_cap_r == $past(sync2_r[PIN_SIO]))
		else $error("external data not captured on clock rise");
	chk_t0_no_check: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && !pmode_r[PM_PROTO_BIT] |=> !check_active)
		else $error("block check active under T=0");
	chk_append_after_last: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && check_active_r && tx_byte.valid && tx_last && (chk_state_r == CHK_IDLE)
		|-> ##[2:3] check_byte.valid)
		else $error("check value not appended after last byte");
	chk_div_read_zero: assert property (@(posedge core_clk) disable iff (!rstn)
		ce && rd_stb && ((addr == ADDR_CARD_CLOCK_DIVIDER) || (addr == ADDR_CONTACT_DIRECTION))
		|=> (rd_data[7:6] == 2'b00) && (rd_data[1:0] == 2'b00 || $past(addr) != ADDR_CONTACT_DIRECTION))
		else $error("unused register bits read nonzero");
endmodule
